// *** rtl/ras_consts.svh ***
// constants for the return address stack block
`ifndef RAS_CONSTS_SVH
`define RAS_CONSTS_SVH
`define RAS_PC_W         21
`define RAS_PTR_W        5
`define RAS_DEPTH        31
`define RAS_PTR_MAX      5'h1f
`define RAS_PTR_RST      5'h00
`define RAS_PC_RST       21'h000000
`define RAS_VEC_HIGH     21'h000008
`define RAS_VEC_LOW      21'h000018
`define RAS_PC_STEP      21'h000002
`define RAS_MEM_TOP_DEF  21'h007fff
`endif

// *** rtl/ras_pkg.sv ***
// types for the return address stack block
package ras_pkg;
    typedef struct packed {
        logic [20:0] pc;
        logic [4:0]  ptr;
        logic        full;
        logic        unf;
        logic        rst_req;
        logic [7:0]  sh_status;
        logic [7:0]  sh_work;
        logic [7:0]  sh_bank;
        logic        restore;
        logic [15:0] fetch;
        logic [20:0] tos;
    } ras_state_t;
endpackage

// *** rtl/ras_stack.sv ***
// return address stack, pointer, flags, fast shadow and fetch limiting
`timescale 1ns/10ps
`include "ras_consts.svh"
module ras_stack
    import ras_pkg::*;
#(
    parameter logic [20:0] MEM_TOP = `RAS_MEM_TOP_DEF
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        overflow_reset_enable,
    input  wire logic        por_event,
    input  wire logic        advance,
    input  wire logic        jump,
    input  wire logic [20:0] jump_target,
    input  wire logic        call_push,
    input  wire logic        irq_high,
    input  wire logic        irq_low,
    input  wire logic        fast_save,
    input  wire logic        ret_pop,
    input  wire logic        fast_restore,
    input  wire logic        push_instr,
    input  wire logic        pop_instr,
    input  wire logic [7:0]  cur_status,
    input  wire logic [7:0]  cur_work,
    input  wire logic [7:0]  cur_bank,
    input  wire logic        ptr_wr,
    input  wire logic [4:0]  ptr_wdata,
    input  wire logic        full_clr,
    input  wire logic        unf_clr,
    input  wire logic        tos_upper_wr,
    input  wire logic        tos_high_wr,
    input  wire logic        tos_low_wr,
    input  wire logic [7:0]  tos_wdata,
    input  wire logic [15:0] mem_rdata,
    output logic [20:0] pc,
    output logic [15:0] fetch_word,
    output logic [4:0]  stack_pointer_reg,
    output logic        stack_full_flag,
    output logic        stack_underflow_flag,
    output logic [7:0]  top_entry_upper,
    output logic [7:0]  top_entry_high,
    output logic [7:0]  top_entry_low,
    output logic        stack_reset_req,
    output logic        shadow_restore,
    output logic [7:0]  shadow_status,
    output logic [7:0]  shadow_work,
    output logic [7:0]  shadow_bank
);
    // all state of the block except the entry array in one packed struct
    ras_state_t  s_reg;
    ras_state_t  s_next;

    // entry 0 is never written; index 0 has no storage behind it
    // no reset on the array: a pointer write may expose unwritten entries
    logic [20:0] mem_reg [1:`RAS_DEPTH];

    // write port into the entry array, driven by the state logic
    logic        wr_en;
    logic [4:0]  wr_idx;
    logic [20:0] wr_val;

    // decoded requests after priority
    logic        any_tos_wr;
    logic        do_ptr_wr;
    logic        do_push;
    logic        do_pop;
    logic        do_tos_wr;

    // pointer position and neighbours
    logic        at_bottom;
    logic        at_top;
    logic        last_slot;
    logic [4:0]  ptr_up;
    logic [4:0]  ptr_down;

    // return address a push saves
    logic [20:0] pc_ret;

    // hardware flag events, kept apart so a clear cannot mask them
    logic        full_event;
    logic        unf_event;
    logic        ovr_reset;
    logic        unf_reset;

    // shadow load strobe and merged top entry bytes
    logic        shadow_load;
    logic [20:0] tos_merged;

    // pointer position tests on the present pointer
    assign at_bottom = (s_reg.ptr == `RAS_PTR_RST);
    assign at_top = (s_reg.ptr == `RAS_PTR_MAX);
    assign ptr_up = s_reg.ptr + 5'h01;
    assign ptr_down = s_reg.ptr - 5'h01;
    // the push that lands in the last entry is the 31st in a row
    assign last_slot = (ptr_up == `RAS_PTR_MAX);

    // pushes save the address of the next word, the return point
    assign pc_ret = s_reg.pc + `RAS_PC_STEP;

    // priority: pointer write, then push, then pop, then byte writes
    assign any_tos_wr = tos_upper_wr | tos_high_wr | tos_low_wr;
    assign do_ptr_wr = ptr_wr;
    assign do_push = ~ptr_wr & (call_push | irq_high | irq_low | push_instr);
    assign do_pop = ~ptr_wr & ~do_push & (ret_pop | pop_instr);
    // byte writes never touch the unbacked entry behind pointer zero
    assign do_tos_wr = ~ptr_wr & ~do_push & ~do_pop & any_tos_wr & ~at_bottom;

    // full: push into the last entry, or any push while parked on it
    assign full_event = do_push & (at_top | last_slot);
    // underflow: a pop of either kind with nothing stacked
    assign unf_event = do_pop & at_bottom;
    // with the option set, underflow and a push into the last entry also ask for a device reset
    assign ovr_reset = do_push & last_slot & overflow_reset_enable;
    assign unf_reset = unf_event & overflow_reset_enable;

    // either interrupt priority or a fast call overwrites the shadow
    assign shadow_load = irq_high | irq_low | fast_save;

    // byte lanes of the top entry; the upper lane carries five bits
    assign tos_merged[20:16] = tos_upper_wr ? tos_wdata[4:0] : s_reg.tos[20:16];
    assign tos_merged[15:8] = tos_high_wr ? tos_wdata : s_reg.tos[15:8];
    assign tos_merged[7:0] = tos_low_wr ? tos_wdata : s_reg.tos[7:0];

    // next state: flow, pointer, entries, flags, shadow and fetch
    always_comb begin
        // defaults: hold everything, strobes low, no array write
        s_next = s_reg;
        wr_en = 1'b0;
        wr_idx = s_reg.ptr;
        wr_val = pc_ret;
        s_next.rst_req = 1'b0;
        s_next.restore = 1'b0;

        // straight-line flow; a jump in the same cycle wins
        if (advance) begin
            s_next.pc = pc_ret;
        end
        if (jump) begin
            s_next.pc = jump_target;
        end

        // pointer and entry array; software pointer writes go first
        if (do_ptr_wr) begin
            s_next.ptr = ptr_wdata;
        end else if (do_push) begin
            wr_en = 1'b1;
            if (at_top) begin
                // parked at the top: overwrite it, pointer stays put
                wr_idx = `RAS_PTR_MAX;
            end else begin
                // increment first, then write the newly selected entry
                s_next.ptr = ptr_up;
                wr_idx = ptr_up;
            end
        end else if (do_pop) begin
            if (!at_bottom) begin
                // entry is read out through tos before the pointer drops
                s_next.ptr = ptr_down;
            end
        end else if (do_tos_wr) begin
            // replace the selected entry with the merged bytes
            wr_en = 1'b1;
            wr_idx = s_reg.ptr;
            wr_val = tos_merged;
        end

        // flow on stack operations; the pc latches are not read here
        if (do_push) begin
            if (irq_high) begin
                s_next.pc = `RAS_VEC_HIGH;
            end else if (irq_low) begin
                s_next.pc = `RAS_VEC_LOW;
            end else if (call_push) begin
                s_next.pc = jump_target;
            end
        end else if (do_pop && ret_pop) begin
            if (at_bottom) begin
                // empty return lands on the reset vector
                s_next.pc = `RAS_PC_RST;
            end else begin
                s_next.pc = s_reg.tos;
            end
        end

        // overflow reset restarts at the reset vector, even over a vector
        if (ovr_reset) begin
            s_next.ptr = `RAS_PTR_RST;
            s_next.pc = `RAS_PC_RST;
        end
        // one-cycle request to the device reset logic
        s_next.rst_req = ovr_reset | unf_reset;

        // instructions sit on word boundaries
        s_next.pc[0] = 1'b0;

        // clears first so a same-cycle hardware event wins
        if (full_clr) begin
            s_next.full = 1'b0;
        end
        if (unf_clr) begin
            s_next.unf = 1'b0;
        end
        if (full_event) begin
            s_next.full = 1'b1;
        end
        if (unf_event) begin
            s_next.unf = 1'b1;
        end
        // power-on clear and the reset are the only other ways out of a flag
        if (por_event) begin
            s_next.full = 1'b0;
            s_next.unf = 1'b0;
        end

        // one-deep shadow of status, working and bank select
        if (shadow_load) begin
            s_next.sh_status = cur_status;
            s_next.sh_work = cur_work;
            s_next.sh_bank = cur_bank;
        end
        // restore strobe to the core, one cycle behind the fast return
        s_next.restore = fast_restore;

        // beyond implemented memory the fetch reads zero, a no-op
        s_next.fetch = (s_reg.pc > MEM_TOP) ? 16'h0000 : mem_rdata;

        // top entry view follows the pointer; a same-cycle write shows through
        if (wr_en && (wr_idx == s_next.ptr)) begin
            s_next.tos = wr_val;
        end else if (s_next.ptr == `RAS_PTR_RST) begin
            s_next.tos = `RAS_PC_RST;
        end else begin
            s_next.tos = mem_reg[s_next.ptr];
        end
    end

    // state register; the asynchronous branch loads constants only
    // clock enable low freezes every field
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // stack storage, written one entry at a time
    always_ff @(posedge mclk) begin
        if (ce && wr_en && wr_idx != `RAS_PTR_RST) begin
            mem_reg[wr_idx] <= wr_val;
        end
    end

    // every output is a field of the state register
    // program flow
    assign pc = s_reg.pc;
    assign fetch_word = s_reg.fetch;

    // pointer and flags
    assign stack_pointer_reg = s_reg.ptr;
    assign stack_full_flag = s_reg.full;
    assign stack_underflow_flag = s_reg.unf;

    // top entry bytes; the unused upper bits read zero
    assign top_entry_upper = {3'h0, s_reg.tos[20:16]};
    assign top_entry_high = s_reg.tos[15:8];
    assign top_entry_low = s_reg.tos[7:0];

    // strobes to the core
    assign stack_reset_req = s_reg.rst_req;
    assign shadow_restore = s_reg.restore;

    // shadow contents for the fast return
    assign shadow_status = s_reg.sh_status;
    assign shadow_work = s_reg.sh_work;
    assign shadow_bank = s_reg.sh_bank;
endmodule

// *** bench/ras_checker.sv ***
// concurrent checks on the return address stack ports
`timescale 1ns/10ps
module ras_checker #(
    parameter logic [20:0] MEM_TOP = 21'h007fff
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        overflow_reset_enable,
    input wire logic        call_push,
    input wire logic        irq_high,
    input wire logic        irq_low,
    input wire logic        fast_save,
    input wire logic        ret_pop,
    input wire logic        fast_restore,
    input wire logic        push_instr,
    input wire logic        pop_instr,
    input wire logic        ptr_wr,
    input wire logic        stack_full_flag,
    input wire logic        stack_underflow_flag,
    input wire logic        stack_reset_req,
    input wire logic        shadow_restore,
    input wire logic [4:0]  ptr_wdata,
    input wire logic [4:0]  stack_pointer_reg,
    input wire logic [7:0]  cur_status,
    input wire logic [7:0]  shadow_status,
    input wire logic [20:0] pc,
    input wire logic [15:0] fetch_word
);
    wire [4:0] sp = stack_pointer_reg;
    // qualified push and pop, pointer writes win over both
    wire psh = ce & ~ptr_wr & (call_push | irq_high | irq_low | push_instr);
    wire pop = ce & ~ptr_wr & ~psh & (ret_pop | pop_instr);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_push; psh && sp < 5'h1e |=> sp == $past(sp) + 5'h01; endproperty
    a_push: assert property (p_push) else $error("push step wrong");
    property p_pop; pop && sp != 5'h00 |=> sp == $past(sp) - 5'h01; endproperty
    a_pop: assert property (p_pop) else $error("pop step wrong");
    property p_vec; psh && irq_high && sp < 5'h1e |=> pc == 21'h000008; endproperty
    a_vec: assert property (p_vec) else $error("vector wrong");
    property p_sat; psh && !overflow_reset_enable && sp == 5'h1f |=> sp == 5'h1f; endproperty
    a_sat: assert property (p_sat) else $error("pointer left top");
    property p_wr; ce && ptr_wr |=> sp == $past(ptr_wdata); endproperty
    a_wr: assert property (p_wr) else $error("pointer write lost");
    property p_unf; pop && ret_pop && sp == 5'h00 |=> stack_underflow_flag && pc == 21'h0;
    endproperty
    a_unf: assert property (p_unf) else $error("underflow wrong");
    property p_ovr; psh && overflow_reset_enable && sp == 5'h1e
        |-> ##[1:2] (stack_reset_req && stack_full_flag); endproperty
    a_ovr: assert property (p_ovr) else $error("no overflow reset");
    property p_fetch; ce && pc > MEM_TOP |=> fetch_word == 16'h0000; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch not zero");
    property p_shd; ce && (irq_high || irq_low || fast_save)
        |=> shadow_status == $past(cur_status); endproperty
    a_shd: assert property (p_shd) else $error("shadow not loaded");
    property p_rest; ce && fast_restore |=> shadow_restore; endproperty
    a_rest: assert property (p_rest) else $error("no restore");
    property p_full; psh && sp == 5'h1e |=> stack_full_flag; endproperty
    a_full: assert property (p_full) else $error("full flag missed");
    property p_ufr; pop && overflow_reset_enable && sp == 5'h00
        |=> stack_reset_req; endproperty
    a_ufr: assert property (p_ufr) else $error("no underflow reset");
endmodule
bind ras_stack ras_checker #(.MEM_TOP(MEM_TOP)) chk_i (.mclk, .rst, .ce, .overflow_reset_enable,
    .call_push, .irq_high, .irq_low, .fast_save, .ret_pop, .fast_restore, .push_instr,
    .pop_instr, .ptr_wr, .stack_full_flag, .stack_underflow_flag, .stack_reset_req,
    .shadow_restore, .ptr_wdata, .stack_pointer_reg, .cur_status, .shadow_status, .pc,
    .fetch_word);

// *** bench/ras_mem_model.sv ***
// program memory model on the fetch side
`timescale 1ns/10ps
module ras_mem_model (
    input  wire logic [20:0] addr,
    output logic      [15:0] rdata
);
    // word follows the address so a stale fetch shows up
    assign rdata = addr[16:1] ^ 16'ha5a5;
endmodule

// *** bench/ras_stack_bench.sv ***
// self-checking bench for the return address stack
`timescale 1ns/10ps
module ras_stack_bench;
    logic        mclk = 0, rst = 1, ore = 0, ce = 1, ff, uf, rr, sr;
    logic [16:0] rq = '0;
    logic [20:0] tgt = '0, pc;
    logic [23:0] cv = 24'h123456;
    logic [15:0] md, fw;
    logic [7:0]  wd = '0, tu, th, tl, ss, sw, sb;
    logic [4:0]  pw = '0, sp;
    int          err_total = 0, comparisons = 0;
    wire  [20:0] tos = {tu[4:0], th, tl};
    always #2 mclk = ~mclk;
    // rq bits: advance jump call irqh irql fsave ret frest push pop ptrwr fclr uclr tu th tl por
    ras_stack #(.MEM_TOP(21'h00003f)) uut (.mclk(mclk), .rst(rst), .ce(ce),
        .overflow_reset_enable(ore), .por_event(rq[16]), .advance(rq[0]), .jump(rq[1]),
        .jump_target(tgt), .call_push(rq[2]), .irq_high(rq[3]), .irq_low(rq[4]),
        .fast_save(rq[5]), .ret_pop(rq[6]), .fast_restore(rq[7]), .push_instr(rq[8]),
        .pop_instr(rq[9]), .cur_status(cv[23:16]), .cur_work(cv[15:8]), .cur_bank(cv[7:0]),
        .ptr_wr(rq[10]), .ptr_wdata(pw), .full_clr(rq[11]), .unf_clr(rq[12]),
        .tos_upper_wr(rq[13]), .tos_high_wr(rq[14]), .tos_low_wr(rq[15]), .tos_wdata(wd),
        .mem_rdata(md), .pc(pc), .fetch_word(fw), .stack_pointer_reg(sp),
        .stack_full_flag(ff), .stack_underflow_flag(uf), .top_entry_upper(tu),
        .top_entry_high(th), .top_entry_low(tl), .stack_reset_req(rr),
        .shadow_restore(sr), .shadow_status(ss), .shadow_work(sw), .shadow_bank(sb));
    ras_mem_model mem (.addr(pc), .rdata(md));
    // one request for one cycle, launched off the falling edge
    task automatic go(input logic [16:0] v);
        @(negedge mclk) rq = v;
        @(negedge mclk) rq = '0;
    endtask
    task automatic chk(input logic [20:0] s, input logic [20:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("BAD %0t saw %h want %h", $time, s, e);
        end
    endtask
    task automatic t_call();
        tgt = 21'h000010;
        go(17'h00002);
        tgt = 21'h000100;
        go(17'h00004);
        chk(pc, 21'h000100);
        chk(tos, 21'h000012);
        go(17'h00008);
        chk(pc, 21'h000008);
        chk(ss, 8'h12);
        cv = 24'h9abcde;
        go(17'h00010);
        chk(pc, 21'h000018);
        chk(sb, 8'hde);
        chk(sp, 5'h03);
        go(17'h00040);
        chk(pc, 21'h00000a);
        go(17'h00040);
        chk(pc, 21'h000102);
        go(17'h00040);
        chk(pc, 21'h000012);
        cv = 24'h445566;
        go(17'h00020);
        chk(sw, 8'h55);
        go(17'h00080);
        chk(sr, 1'b1);
        @(negedge mclk);
        chk(sr, 1'b0);
        // clock enable low: a push must leave the pointer alone
        ce = 1'b0;
        go(17'h00100);
        chk(sp, 5'h00);
        ce = 1'b1;
    endtask
    task automatic t_full();
        pw = 5'h00;
        go(17'h00400);
        repeat (30) go(17'h00100);
        chk(ff, 1'b0);
        chk(tos, 21'h000014);
        go(17'h00100);
        chk(ff, 1'b1);
        chk(sp, 5'h1f);
        tgt = 21'h000040;
        go(17'h00002);
        go(17'h00100);
        chk(sp, 5'h1f);
        chk(tos, 21'h000042);
        go(17'h00800);
        chk(ff, 1'b0);
    endtask
    task automatic t_unf();
        pw = 5'h00;
        go(17'h00400);
        go(17'h00040);
        chk(pc, 21'h000000);
        chk(uf, 1'b1);
        go(17'h10000);
        chk(uf, 1'b0);
        // empty pop together with a clear: the set wins
        go(17'h01040);
        chk(uf, 1'b1);
        go(17'h01000);
        chk(uf, 1'b0);
    endtask
    // irq lines stay idle around the top entry access
    task automatic t_tos();
        pw = 5'h05;
        go(17'h00400);
        wd = 8'h01;
        go(17'h02000);
        wd = 8'h23;
        go(17'h04000);
        wd = 8'h46;
        go(17'h08000);
        chk(tos, 21'h012346);
        go(17'h00040);
        chk(pc, 21'h012346);
        chk(sp, 5'h04);
        @(negedge mclk);
        chk(fw, 16'h0000);
        tgt = 21'h000020;
        go(17'h00002);
        @(negedge mclk);
        chk(fw, 16'ha5b5);
        go(17'h00001);
        chk(pc, 21'h000022);
        go(17'h00200);
        chk(sp, 5'h03);
        chk(pc, 21'h000022);
    endtask
    task automatic t_ovr();
        ore = 1'b1;
        pw = 5'h1e;
        go(17'h00400);
        go(17'h00100);
        chk(rr, 1'b1);
        repeat (2) @(negedge mclk);
        chk(rr, 1'b0);
        chk(ff, 1'b1);
        chk(sp, 5'h00);
        go(17'h00040);
        chk(rr, 1'b1);
        chk(uf, 1'b1);
    endtask
    task automatic tally_and_finish();
        $display("mismatches %0d of %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // hang guard, far beyond the 150 or so cycles needed
    initial begin
        #20000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        t_call();
        t_full();
        t_unf();
        t_tos();
        t_ovr();
        tally_and_finish();
    end
endmodule
